// >>> hdl/ledps_pkg.sv
// ledps_pkg: constants, field layouts and carrier types of the LED control and page select block.
// assumes a 40 MHz device clock and AXI4-Lite register access with 32-bit data.
package ledps_pkg;
  // ---------------------------------------------------------------
  // register indices and byte address width
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_LED_MODE = 6'h1D;
  localparam logic [5:0] IDX_LED_BEHAV = 6'h1E;
  localparam logic [5:0] IDX_PAGE = 6'h1F;
  localparam logic [5:0] IDX_PULSE_DUTY = 6'h20;
  localparam logic [5:0] IDX_LED_STATUS = 6'h21;
  localparam logic [5:0] IDX_FIRST_PAGED = 6'h10;
  localparam int ADDR_W = 8;
  // ---------------------------------------------------------------
  // reset values, masks, page codes and response codes
  // ---------------------------------------------------------------
  localparam logic [15:0] LED_MODE_RST = 16'h8021;
  localparam logic [15:0] LED_BEHAV_RST = 16'h0400;
  localparam logic [15:0] LED_BEHAV_WMASK = 16'hDDEF;
  localparam logic [15:0] PAGE_RST = 16'h0000;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT1 = 16'h0001;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;
  localparam logic [15:0] PAGE_EXT3 = 16'h0003;
  localparam logic [15:0] PAGE_EXT4 = 16'h0004;
  localparam logic [15:0] PAGE_GPIO = 16'h0010;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // led modes handled here
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_LINK_ACT = 4'h0;
  localparam logic [3:0] MODE_ACT = 4'h1;
  localparam logic [3:0] MODE_DUPLEX_COL = 4'h2;
  localparam logic [3:0] MODE_FIBER_ACT = 4'h3;
  localparam logic [3:0] MODE_COLLISION = 4'h4;
  localparam logic [3:0] MODE_LINK = 4'h5;
  localparam logic [3:0] MODE_FORCE_OFF = 4'hE;
  localparam logic [3:0] MODE_FORCE_ON = 4'hF;
  // ---------------------------------------------------------------
  // timing: one base tick of 25 ms; blink half periods and stretches in ticks
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 25_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int PULSE_PERIOD_NS = 200_000;
  localparam int PULSE_CYCLES = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [15:0] PULSE_DUTY_RST = 16'h0FA0;
  localparam logic [1:0] RATE_RST = 2'h1;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic combine_dis;
    logic act_split;
    logic rsvd13;
    logic pulse_en;
    logic [1:0] rate;
    logic rsvd9;
    logic [3:0] stretch_sel;
    logic rsvd4;
    logic [3:0] led_combine_dis;
  } ledps_behav_t;
  typedef struct packed {
    logic cu_link;
    logic fi_link;
    logic cu_tx_act;
    logic cu_rx_act;
    logic fi_tx_act;
    logic fi_rx_act;
    logic duplex;
    logic collision;
  } ledps_media_t;
  typedef enum logic [2:0] {SP_MAIN, SP_EXT1, SP_EXT2, SP_EXT3, SP_EXT4, SP_GPIO} ledps_space_t;
endpackage

// >>> hdl/ledps_top.sv
// ledps_top: per-port LED mode/behaviour registers, LED drive and management page select.
// assumes media status inputs and the first port's rate come from logic on aclk.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - four sticky mode fields, documented reset values
// - combine bit 0 merges copper and fiber
// - activity select splits tx and rx
// - pulsing enable drives 5 kHz duty pulses
// - rate code picks blink and stretch
// - only first port rate field acts
// - per-led combine disable, link or duplex only
// - page zero keeps main register space
// - pages one to four redirect 16-30
// - gpio page redirects 0-30, 31 stays
// - registers 0-15 unaffected by extended pages
module ledps_top #(
  parameter bit IS_FIRST_PORT = 1'b1,
  parameter int TICK_CYC = ledps_pkg::TICK_CYCLES,
  parameter int PULSE_CYC = ledps_pkg::PULSE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ledps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ledps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ledps_pkg::ledps_media_t media,
  input wire logic [1:0] first_port_rate,
  output logic [1:0] rate_field,
  input wire logic [4:0] mgmt_reg_num,
  output ledps_pkg::ledps_space_t mgmt_space,
  output logic [3:0] led_on
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic ledps_pkg::ledps_space_t space_of(input logic [4:0] num,
                                                        input logic [15:0] page);
    ledps_pkg::ledps_space_t sp;
    sp = ledps_pkg::SP_MAIN;
    if (page == ledps_pkg::PAGE_GPIO && num != 5'h1F)
      sp = ledps_pkg::SP_GPIO;
    else if (num >= ledps_pkg::IDX_FIRST_PAGED[4:0] && num != 5'h1F)
    begin
      case (page)
        ledps_pkg::PAGE_EXT1: sp = ledps_pkg::SP_EXT1;
        ledps_pkg::PAGE_EXT2: sp = ledps_pkg::SP_EXT2;
        ledps_pkg::PAGE_EXT3: sp = ledps_pkg::SP_EXT3;
        ledps_pkg::PAGE_EXT4: sp = ledps_pkg::SP_EXT4;
        default: sp = ledps_pkg::SP_MAIN;
      endcase
    end
    return sp;
  endfunction

  // led mode and behaviour registers are served here only when the page keeps them in main space; page, duty and status always are
  function automatic logic is_local(input logic [5:0] idx, input logic [15:0] page);
    logic hit;
    hit = 1'b0;
    if (idx == ledps_pkg::IDX_PAGE || idx == ledps_pkg::IDX_PULSE_DUTY
        || idx == ledps_pkg::IDX_LED_STATUS)
      hit = 1'b1;
    else if (idx == ledps_pkg::IDX_LED_MODE || idx == ledps_pkg::IDX_LED_BEHAV)
      hit = (space_of(idx[4:0], page) == ledps_pkg::SP_MAIN);
    return hit;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0])
      v[7:0] = (old[7:0] & ~mask[7:0]) | (wd[7:0] & mask[7:0]);
    if (strb[1])
      v[15:8] = (old[15:8] & ~mask[15:8]) | (wd[15:8] & mask[15:8]);
    return v;
  endfunction

  // blink half period in ticks: 2.5/5/10/20 Hz
  function automatic logic [4:0] half_ticks(input logic [1:0] rate);
    return 5'h8 >> rate;
  endfunction

  // stretch length in ticks: 400/200/100/50 ms
  function automatic logic [4:0] stretch_ticks(input logic [1:0] rate);
    return 5'h10 >> rate;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] led_mode_reg;
  ledps_pkg::ledps_behav_t behav_reg;
  logic [15:0] page_reg;
  logic [15:0] duty_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [5:0] aw_idx_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic [5:0] ar_idx;
  logic [1:0] eff_rate;
  logic [31:0] rd_val;

  assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign ar_idx = s_axi_araddr[ledps_pkg::ADDR_W-1:2];
  assign eff_rate = IS_FIRST_PORT ? behav_reg.rate : first_port_rate;

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ledps_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= ~aw_have_reg & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_have_reg & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[ledps_pkg::ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_local(aw_idx_reg, page_reg) ? ledps_pkg::RESP_OKAY
                                                     : ledps_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_mode_reg <= ledps_pkg::LED_MODE_RST;
      behav_reg <= ledps_pkg::LED_BEHAV_RST;
      page_reg <= ledps_pkg::PAGE_RST;
      duty_reg <= ledps_pkg::PULSE_DUTY_RST;
    end
    else if (ce && do_write && is_local(aw_idx_reg, page_reg))
    begin
      case (aw_idx_reg)
        ledps_pkg::IDX_LED_MODE:
          led_mode_reg <= merge16(led_mode_reg, wdata_reg, wstrb_reg, 16'hFFFF);
        ledps_pkg::IDX_LED_BEHAV:
          behav_reg <= merge16(behav_reg, wdata_reg, wstrb_reg,
                               ledps_pkg::LED_BEHAV_WMASK);
        ledps_pkg::IDX_PAGE:
          page_reg <= merge16(page_reg, wdata_reg, wstrb_reg, 16'hFFFF);
        ledps_pkg::IDX_PULSE_DUTY:
          duty_reg <= merge16(duty_reg, wdata_reg, wstrb_reg, 16'hFFFF);
        default:
          page_reg <= page_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_val = 32'h00000000;
    case (ar_idx)
      ledps_pkg::IDX_LED_MODE: rd_val = {16'h0000, led_mode_reg};
      ledps_pkg::IDX_LED_BEHAV: rd_val = {16'h0000, behav_reg & ledps_pkg::LED_BEHAV_WMASK};
      ledps_pkg::IDX_PAGE: rd_val = {16'h0000, page_reg};
      ledps_pkg::IDX_PULSE_DUTY: rd_val = {16'h0000, duty_reg};
      ledps_pkg::IDX_LED_STATUS: rd_val = {24'h000000, eff_rate, 2'h0, led_on};
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ledps_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        // redirected addresses belong to another page: answer error, data zero
        if (is_local(ar_idx, page_reg))
        begin
          s_axi_rdata <= rd_val;
          s_axi_rresp <= ledps_pkg::RESP_OKAY;
        end
        else
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= ledps_pkg::RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // page decode for management accesses
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mgmt_space <= ledps_pkg::SP_MAIN;
      rate_field <= ledps_pkg::RATE_RST;
    end
    else if (ce)
    begin
      mgmt_space <= space_of(mgmt_reg_num, page_reg);
      rate_field <= behav_reg.rate;
    end
  end

  // ---------------------------------------------------------------
  // timebase: 25 ms tick, blink phase, 5 kHz pulse
  // ---------------------------------------------------------------
  logic [$clog2(TICK_CYC)-1:0] tick_cnt_reg;
  logic tick;
  logic [4:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic [$clog2(PULSE_CYC)-1:0] pulse_cnt_reg;

  assign tick = (tick_cnt_reg == ($clog2(TICK_CYC))'(TICK_CYC - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_reg <= '0;
      blink_cnt_reg <= 5'h00;
      blink_phase_reg <= 1'b0;
    end
    else if (ce)
    begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
      if (tick)
      begin
        // the rate of the first port governs every pin
        if (blink_cnt_reg + 5'h01 >= half_ticks(eff_rate))
        begin
          blink_cnt_reg <= 5'h00;
          blink_phase_reg <= ~blink_phase_reg;
        end
        else
          blink_cnt_reg <= blink_cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pulse_cnt_reg <= '0;
    else if (ce)
      pulse_cnt_reg <= (pulse_cnt_reg == ($clog2(PULSE_CYC))'(PULSE_CYC - 1))
                       ? '0 : pulse_cnt_reg + 1'b1;
  end

  // ---------------------------------------------------------------
  // indication sources and per-led drive
  // ---------------------------------------------------------------
  logic link_any;
  logic act_main;
  logic act_fiber;
  logic [3:0] act_raw;
  logic [3:0] base_raw;
  logic [4:0] stretch_reg [4];

  always_comb
  begin
    logic cmb;
    cmb = ~behav_reg.combine_dis;
    link_any = media.cu_link | (cmb & media.fi_link);
    if (behav_reg.act_split)
    begin
      act_main = media.cu_tx_act | (cmb & media.fi_tx_act);
      act_fiber = media.cu_rx_act | (cmb & media.fi_rx_act);
    end
    else
    begin
      act_main = media.cu_tx_act | media.cu_rx_act
                 | (cmb & (media.fi_tx_act | media.fi_rx_act));
      act_fiber = act_main;
    end
    for (int i = 0; i < 4; i++)
    begin
      act_raw[i] = 1'b0;
      base_raw[i] = 1'b0;
      case (led_mode_reg[4*i +: 4])
        ledps_pkg::MODE_LINK_ACT:
        begin
          base_raw[i] = link_any;
          act_raw[i] = link_any & act_main & ~behav_reg.led_combine_dis[i];
        end
        ledps_pkg::MODE_ACT: act_raw[i] = act_main;
        ledps_pkg::MODE_DUPLEX_COL:
        begin
          base_raw[i] = media.duplex;
          act_raw[i] = media.collision & ~behav_reg.led_combine_dis[i];
        end
        ledps_pkg::MODE_FIBER_ACT: act_raw[i] = act_fiber;
        ledps_pkg::MODE_COLLISION: act_raw[i] = media.collision;
        ledps_pkg::MODE_LINK: base_raw[i] = link_any;
        ledps_pkg::MODE_FORCE_ON: base_raw[i] = 1'b1;
        default: base_raw[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 4; i++)
        stretch_reg[i] <= 5'h00;
    end
    else if (ce)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (act_raw[i])
          stretch_reg[i] <= stretch_ticks(eff_rate);
        else if (tick && stretch_reg[i] != 5'h00)
          stretch_reg[i] <= stretch_reg[i] - 5'h01;
      end
    end
  end

  // activity inverts the base indication, so a lit link led flickers off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      led_on <= 4'h0;
    else if (ce)
    begin
      for (int i = 0; i < 4; i++)
      begin
        logic ind;
        logic lit;
        ind = behav_reg.stretch_sel[i] ? (stretch_reg[i] != 5'h00)
                                       : (act_raw[i] & blink_phase_reg);
        lit = base_raw[i] ^ ind;
        led_on[i] <= lit & (~behav_reg.pulse_en
                            | (16'(pulse_cnt_reg) < duty_reg));
      end
    end
  end
endmodule

// >>> sim/ledps_media_src.sv
// ledps_media_src: far-side media status source feeding the led logic.
// assumes the bench sets the wanted status bits; output is registered on aclk.
`timescale 1ns/1ps
module ledps_media_src (
  input wire logic aclk,
  input wire logic [7:0] want,
  output ledps_pkg::ledps_media_t media
);
  // registered so status changes never land in the edge that samples them
  always_ff @(posedge aclk)
  begin
    media <= ledps_pkg::ledps_media_t'(want);
  end
endmodule

// >>> sim/ledps_props.sv
// ledps_props: port-level checks of the register bus and page decode.
// assumes binding onto ledps_top with ce mostly high.
`timescale 1ns/1ps
module ledps_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] mgmt_reg_num,
  input wire ledps_pkg::ledps_space_t mgmt_space
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property ((ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready) ##1 ce |=> s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == ledps_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read carries data");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper half not zero");
  a_page_reg_main: assert property (ce && mgmt_reg_num == 5'h1F
    |=> mgmt_space == ledps_pkg::SP_MAIN) else $error("page register redirected");
  a_low_regs: assert property (ce && mgmt_reg_num < 5'h10
    |=> mgmt_space inside {ledps_pkg::SP_MAIN, ledps_pkg::SP_GPIO})
    else $error("low register sent to extended page");
  a_ext_high: assert property ($past(ce) && mgmt_space inside {ledps_pkg::SP_EXT1,
    ledps_pkg::SP_EXT2, ledps_pkg::SP_EXT3, ledps_pkg::SP_EXT4}
    |-> $past(mgmt_reg_num) >= 5'h10)
    else $error("extended page below register 16");
endmodule
bind ledps_top ledps_props u_props (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
  .s_axi_arvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mgmt_reg_num,
  .mgmt_space);

// >>> sim/test_led_control_and_page_select.sv
// test_led_control_and_page_select: self-checking bench for ledps_top.
// assumes the media source model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_led_control_and_page_select;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, media_want;
  logic [31:0] s_axi_wdata, s_axi_rdata, p1_rdata;
  logic [3:0] s_axi_wstrb, led_on;
  logic [1:0] s_axi_bresp, s_axi_rresp, first_port_rate, rate_field;
  logic [4:0] mgmt_reg_num;
  logic [15:0] d;
  ledps_pkg::ledps_media_t media;
  ledps_pkg::ledps_space_t mgmt_space;
  logic [33:0] rq[$];
  logic [15:0] pages[8] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h10, 16'h5, 16'hFFFF};
  int fails, checked;
  // ---------------------------------------------------------------
  // design and far side
  // ---------------------------------------------------------------
  ledps_top #(.TICK_CYC(10), .PULSE_CYC(16)) dut (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .media, .first_port_rate,
    .rate_field, .mgmt_reg_num, .mgmt_space, .led_on);
  ledps_media_src u_src (.aclk, .want(media_want), .media);
  // a second port in lock-step on the same bus: its rate must follow first_port_rate
  ledps_top #(.IS_FIRST_PORT(1'b0), .TICK_CYC(10), .PULSE_CYC(16)) u_port1 (.aclk, .aresetn,
    .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(p1_rdata), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready, .media, .first_port_rate, .rate_field(), .mgmt_reg_num,
    .mgmt_space(), .led_on());
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // entered just after a rising edge; bready comes late at random to stall the slave
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready)
      begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready)
      begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    cmp(34'(s_axi_bresp), 34'(ledps_pkg::RESP_OKAY), "bresp");
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    rq.push_back(exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic lc(input logic [3:0] exp);
    repeat (4) @(posedge aclk);
    #1 cmp(34'(led_on), 34'(exp), "led");
  endtask
  function automatic ledps_pkg::ledps_space_t sp(input logic [15:0] p, input logic [4:0] r);
    if (r == 5'h1F)
      return ledps_pkg::SP_MAIN;
    if (p == 16'h0010)
      return ledps_pkg::SP_GPIO;
    if (r >= 5'h10 && p >= 16'h0001 && p <= 16'h0004)
      return ledps_pkg::ledps_space_t'(p[2:0]);
    return ledps_pkg::SP_MAIN;
  endfunction
  // ---------------------------------------------------------------
  // read monitor and watchdog
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "read");
  end
  initial
  begin
    #500_000;
    fails++;
    finish_test;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, media_want, first_port_rate} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    mgmt_reg_num = 5'h0;
    fails = 0;
    checked = 0;
    void'($urandom(32'h2274));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h74, 34'h8021);
    rd(8'h78, 34'h0400);
    rd(8'h7C, 34'h0);
    repeat (3)
    begin
      d = 16'($urandom);
      wr(8'h74, d);
      rd(8'h74, {18'h0, d});
    end
    wr(8'h78, 16'hFFFF);
    rd(8'h78, 34'hDDEF);
    rd(8'h40, {ledps_pkg::RESP_SLVERR, 32'h0});
    wr(8'h74, 16'hEEEE);
    for (int r = 0; r < 4; r++)
    begin
      first_port_rate <= 2'($urandom);
      wr(8'h78, {4'h0, 2'(r), 10'h0});
      rd(8'h84, 34'(r << 6));
      cmp(34'(rate_field), 34'(r), "rate");
      cmp(34'(p1_rdata[7:6]), 34'(first_port_rate), "port rate");
    end
    wr(8'h74, 16'hFFFF);
    wr(8'h78, 16'h0400);
    lc(4'hF);
    wr(8'h80, 16'h0);
    wr(8'h78, 16'h1400);
    lc(4'h0);
    wr(8'h78, 16'h0400);
    lc(4'hF);
    wr(8'h74, 16'h5555);
    media_want <= 8'h40;
    lc(4'hF);
    wr(8'h78, 16'h8400);
    lc(4'h0);
    media_want <= 8'h80;
    lc(4'hF);
    wr(8'h74, 16'h0000);
    wr(8'h78, 16'h05EA);
    media_want <= 8'hA0;
    lc(4'hA);
    media_want <= 8'h20;
    wr(8'h78, 16'h4540);
    wr(8'h74, 16'h3E1E);
    lc(4'h2);
    wr(8'h78, 16'h0540);
    lc(4'hA);
    foreach (pages[i])
    begin
      wr(8'h7C, pages[i]);
      if (pages[i] == 16'h1)
        rd(8'h74, {ledps_pkg::RESP_SLVERR, 32'h0});
      for (int r = 0; r < 32; r++)
      begin
        mgmt_reg_num <= 5'(r);
        repeat (2) @(posedge aclk);
        #1 cmp(34'(mgmt_space), 34'(sp(pages[i], 5'(r))), "space");
      end
    end
    wr(8'h7C, 16'h0);
    rd(8'h74, 34'h3E1E);
    wr(8'h7C, 16'h0010);
    ce <= 1'b0;
    mgmt_reg_num <= 5'h02;
    repeat (3) @(posedge aclk);
    #1 cmp(34'(mgmt_space), 34'(ledps_pkg::SP_MAIN), "frozen");
    @(posedge aclk);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    #1 cmp(34'(mgmt_space), 34'(ledps_pkg::SP_GPIO), "gpio");
    repeat (4) @(posedge aclk);
    finish_test;
  end
endmodule
